/* common/modem_cfg_pkg.sv */
// Constants for the modem sync, preamble and channel-step configuration block.
// Assumes an 8-bit register port with 6-bit addresses, as on the chip's serial port.
package modem_cfg_pkg;

  // Register offsets
  localparam logic [5:0] SYNC_CFG_ADDR = 6'h12;
  localparam logic [5:0] PREAMBLE_FEC_ADDR = 6'h13;
  localparam logic [5:0] STEP_FINE_ADDR = 6'h14;

  // Field positions
  localparam int SYNC_MODE_LSB = 0;
  localparam int SYNC_MODE_MSB = 2;
  localparam int FEC_BIT = 7;
  localparam int PREAMBLE_LSB = 4;
  localparam int PREAMBLE_MSB = 6;
  localparam int STEP_EXP_LSB = 0;
  localparam int STEP_EXP_MSB = 1;
  localparam int CS_GATE_BIT = 2;

  // Reset values
  localparam logic [2:0] SYNC_MODE_RST = 3'h2;
  localparam logic FEC_RST = 1'b0;
  localparam logic [2:0] PREAMBLE_RST = 3'h2;
  localparam logic [1:0] STEP_EXP_RST = 2'h2;
  localparam logic [7:0] STEP_MANT_RST = 8'hF8;

  // Sync match thresholds, in matching bits
  localparam logic [5:0] MATCH_15_OF_16 = 6'h0F;
  localparam logic [5:0] MATCH_16_OF_16 = 6'h10;
  localparam logic [5:0] MATCH_30_OF_32 = 6'h1E;

  // Sync mode low bits
  localparam logic [1:0] SYNC_NONE = 2'h0;
  localparam logic [1:0] SYNC_16_LOOSE = 2'h1;
  localparam logic [1:0] SYNC_16_EXACT = 2'h2;
  localparam logic [1:0] SYNC_32 = 2'h3;

  // Preamble length in bytes, indexed by code
  localparam logic [7:0][4:0] PREAMBLE_BYTES = {
    5'h18, 5'h10, 5'h0C, 5'h08, 5'h06, 5'h04, 5'h03, 5'h02
  };

  // Step is (256 + mantissa) << exponent, in units of crystal / 2^18
  localparam logic [8:0] STEP_BASE = 9'h100;
  localparam int STEP_W = 12;
  localparam int BASE_W = 24;
  // Base word is in crystal / 2^16 units, step in crystal / 2^18
  localparam int BASE_TO_STEP_SHIFT = 2;
  localparam int FREQ_W = 27;

endpackage : modem_cfg_pkg

/* verilog/sync_correlator.sv */
// Sync word correlator: shifts received bits and counts matching positions.
// Assumes one received bit per cycle with rx_bit_valid high, synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module sync_correlator
  import modem_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic [15:0] sync_word,
  output logic [5:0] match16,
  output logic [5:0] match32,
  output logic [5:0] fill
);

  logic [31:0] shift_q;
  logic [31:0] shift_d;
  logic [5:0] fill_q;
  logic [5:0] fill_d;
  logic [31:0] agree;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    shift_d = shift_q;
    fill_d = fill_q;
    if (clear)
    begin
      shift_d = 32'h0;
      fill_d = 6'h00;
    end
    else if (bit_valid)
    begin
      shift_d = {shift_q[30:0], bit_in};
      if (fill_q != 6'h20)
        fill_d = fill_q + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_q <= 32'h0;
      fill_q <= 6'h00;
    end
    else
    begin
      shift_q <= shift_d;
      fill_q <= fill_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Repeated sync word forms the 32-bit pattern
  assign agree = ~(shift_q ^ {sync_word, sync_word});

  always_comb
  begin
    match16 = 6'h00;
    match32 = 6'h00;
    for (int i = 0; i < 32; i++)
    begin
      match32 = match32 + {5'h00, agree[i]};
      if (i < 16)
        match16 = match16 + {5'h00, agree[i]};
    end
  end

  assign fill = fill_q;

endmodule : sync_correlator
`default_nettype wire

/* verilog/modem_sync_preamble_hop_cfg.sv */
// Modem configuration bank: sync qualifier, FEC and preamble length, channel step.
// Assumes a host register port synchronous to clk and a bit-serial demodulator feed.
//
// Notes on behaviour
// - Sync qualifier mode is three bits at 2:0, resetting to 2.
// - Mode 0: no preamble or sync sent, no sync search in receive.
// - Mode 1 accepts 15 of 16 sync bits; mode 2 needs all 16.
// - Mode 3 searches a 32-bit sync word, accepting 30 of 32 bits.
// - Modes 3 and 7 transmit the 16-bit sync word twice in a row.
// - Mode 4: no preamble or sync; reception qualified by carrier sense only.
// - Modes 5, 6, 7 use criteria of 1, 2, 3 plus carrier sense.
// - Bit 7 enables FEC with interleaving on payload; resets to off.
// - Preamble code at 6:4 maps to 2,3,4,6,8,12,16,24 bytes; resets to 2.
// - Step exponent is two bits at 1:0, resetting to 2.
// - Step mantissa fills bits 7:0 of its own register, resetting to 248.
// - Step equals crystal/2^18 times (256 + mantissa) times 2^exponent, unsigned.
// - Operating frequency is base plus step times channel index.
`timescale 1ns/100ps
`default_nettype none
module modem_sync_preamble_hop_cfg
  import modem_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] packet_ctrl_low,
  input wire logic rx_enable,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic carrier_sense,
  input wire logic [15:0] sync_word,
  input wire logic [23:0] base_freq,
  input wire logic [7:0] hop_index,
  output logic fwd_err_corr_on,
  output logic fec_length_conflict,
  output logic [4:0] preamble_bytes,
  output logic tx_preamble_sync_on,
  output logic tx_sync_twice,
  output logic rx_search_on,
  output logic rx_cs_gate,
  output logic rx_qualified,
  output logic [11:0] hop_step,
  output logic [26:0] op_freq
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [2:0] sync_mode_q;
  logic [2:0] sync_mode_d;
  logic fec_q;
  logic fec_d;
  logic [2:0] preamble_code_q;
  logic [2:0] preamble_code_d;
  logic [1:0] hop_step_exponent_q;
  logic [1:0] hop_step_exponent_d;
  logic [7:0] hop_step_mantissa_q;
  logic [7:0] hop_step_mantissa_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb
  begin
    sync_mode_d = sync_mode_q;
    fec_d = fec_q;
    preamble_code_d = preamble_code_q;
    hop_step_exponent_d = hop_step_exponent_q;
    hop_step_mantissa_d = hop_step_mantissa_q;
    if (reg_wr)
    begin
      case (reg_addr)
        SYNC_CFG_ADDR:
          sync_mode_d = reg_wdata[SYNC_MODE_MSB:SYNC_MODE_LSB];
        PREAMBLE_FEC_ADDR:
        begin
          fec_d = reg_wdata[FEC_BIT];
          preamble_code_d = reg_wdata[PREAMBLE_MSB:PREAMBLE_LSB];
          hop_step_exponent_d = reg_wdata[STEP_EXP_MSB:STEP_EXP_LSB];
        end
        STEP_FINE_ADDR:
          hop_step_mantissa_d = reg_wdata;
        default:
          ;
      endcase
    end
  end

  // Read data follows the address one cycle later; unmapped reads zero
  always_comb
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      SYNC_CFG_ADDR:
        rdata_d[SYNC_MODE_MSB:SYNC_MODE_LSB] = sync_mode_q;
      PREAMBLE_FEC_ADDR:
      begin
        rdata_d[FEC_BIT] = fec_q;
        rdata_d[PREAMBLE_MSB:PREAMBLE_LSB] = preamble_code_q;
        rdata_d[STEP_EXP_MSB:STEP_EXP_LSB] = hop_step_exponent_q;
      end
      STEP_FINE_ADDR:
        rdata_d = hop_step_mantissa_q;
      default:
        rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_mode_q <= SYNC_MODE_RST;
      fec_q <= FEC_RST;
      preamble_code_q <= PREAMBLE_RST;
      hop_step_exponent_q <= STEP_EXP_RST;
      hop_step_mantissa_q <= STEP_MANT_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      sync_mode_q <= sync_mode_d;
      fec_q <= fec_d;
      preamble_code_q <= preamble_code_d;
      hop_step_exponent_q <= hop_step_exponent_d;
      hop_step_mantissa_q <= hop_step_mantissa_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sync qualifier decode, registered so every output is a flop

  logic [1:0] sync_kind;
  logic cs_gate;
  logic [5:0] threshold;
  logic tx_pre_on_q;
  logic tx_pre_on_d;
  logic tx_twice_q;
  logic tx_twice_d;
  logic search_q;
  logic search_d;
  logic cs_gate_q;
  logic cs_gate_d;
  logic [4:0] pre_bytes_q;
  logic [4:0] pre_bytes_d;
  logic fec_out_q;
  logic fec_out_d;
  logic conflict_q;
  logic conflict_d;

  assign sync_kind = sync_mode_q[1:0];
  assign cs_gate = sync_mode_q[CS_GATE_BIT];

  always_comb
  begin
    threshold = MATCH_16_OF_16;
    case (sync_kind)
      SYNC_16_LOOSE:
        threshold = MATCH_15_OF_16;
      SYNC_16_EXACT:
        threshold = MATCH_16_OF_16;
      SYNC_32:
        threshold = MATCH_30_OF_32;
      default:
        threshold = MATCH_16_OF_16;
    endcase
  end

  always_comb
  begin
    tx_pre_on_d = (sync_kind != SYNC_NONE);
    tx_twice_d = (sync_kind == SYNC_32);
    search_d = rx_enable && (sync_kind != SYNC_NONE);
    cs_gate_d = cs_gate;
    pre_bytes_d = PREAMBLE_BYTES[preamble_code_q];
    fec_out_d = fec_q;
    // Flag only: the host is trusted to keep FEC with fixed length
    conflict_d = fec_q && (packet_ctrl_low != 2'h0);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_pre_on_q <= 1'b1;
      tx_twice_q <= 1'b0;
      search_q <= 1'b0;
      cs_gate_q <= 1'b0;
      pre_bytes_q <= PREAMBLE_BYTES[PREAMBLE_RST];
      fec_out_q <= FEC_RST;
      conflict_q <= 1'b0;
    end
    else
    begin
      tx_pre_on_q <= tx_pre_on_d;
      tx_twice_q <= tx_twice_d;
      search_q <= search_d;
      cs_gate_q <= cs_gate_d;
      pre_bytes_q <= pre_bytes_d;
      fec_out_q <= fec_out_d;
      conflict_q <= conflict_d;
    end
  end

  assign tx_preamble_sync_on = tx_pre_on_q;
  assign tx_sync_twice = tx_twice_q;
  assign rx_search_on = search_q;
  assign rx_cs_gate = cs_gate_q;
  assign preamble_bytes = pre_bytes_q;
  assign fwd_err_corr_on = fec_out_q;
  assign fec_length_conflict = conflict_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receive qualification

  logic [5:0] match16;
  logic [5:0] match32;
  logic [5:0] fill;
  logic [5:0] score;
  logic [5:0] need_fill;
  logic shifted_q;
  logic shifted_d;
  logic cs_prev_q;
  logic cs_prev_d;
  logic qual_q;
  logic qual_d;
  logic corr_clear;

  // Restart the search after a hit or while idle, so one word gives one pulse
  assign corr_clear = !search_q || qual_q;

  sync_correlator u_corr (
    .clk(clk),
    .arst_n(arst_n),
    .clear(corr_clear),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .sync_word(sync_word),
    .match16(match16),
    .match32(match32),
    .fill(fill)
  );

  always_comb
  begin
    score = (sync_kind == SYNC_32) ? match32 : match16;
    need_fill = (sync_kind == SYNC_32) ? MATCH_16_OF_16 + MATCH_16_OF_16 : MATCH_16_OF_16;
    shifted_d = rx_bit_valid && !corr_clear;
    cs_prev_d = carrier_sense;
    qual_d = 1'b0;
    if (rx_enable && !qual_q)
    begin
      if (sync_kind == SYNC_NONE)
        qual_d = cs_gate && carrier_sense && !cs_prev_q;
      else if (shifted_q && search_q && fill >= need_fill)
        qual_d = (score >= threshold) && (!cs_gate || carrier_sense);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shifted_q <= 1'b0;
      cs_prev_q <= 1'b0;
      qual_q <= 1'b0;
    end
    else
    begin
      shifted_q <= shifted_d;
      cs_prev_q <= cs_prev_d;
      qual_q <= qual_d;
    end
  end

  assign rx_qualified = qual_q;

  ////////////////////////////////////////////////////////////////////////////
  // Channel step and operating frequency

  logic [11:0] step_q;
  logic [11:0] step_d;
  logic [26:0] freq_q;
  logic [26:0] freq_d;
  logic [19:0] offset;

  always_comb
  begin
    // Unsigned; units of crystal / 2^18
    step_d = 12'({STEP_BASE[8], hop_step_mantissa_q}) << hop_step_exponent_q;
    offset = 20'(step_q) * 20'(hop_index);
    freq_d = FREQ_W'({base_freq, 2'b00}) + FREQ_W'(offset);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_q <= 12'h000;
      freq_q <= 27'h0000000;
    end
    else
    begin
      step_q <= step_d;
      freq_q <= freq_d;
    end
  end

  assign hop_step = step_q;
  assign op_freq = freq_q;

endmodule : modem_sync_preamble_hop_cfg
`default_nettype wire

/* tb/modem_cfg_sva.sv */
// Checker for the modem configuration bank, bound to its top ports.
// Assumes host writes are single-cycle strobes on clk.
`timescale 1ns/100ps
`default_nettype none
module modem_cfg_sva
  import modem_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] packet_ctrl_low,
  input wire logic rx_enable,
  input wire logic [23:0] base_freq,
  input wire logic [7:0] hop_index,
  input wire logic fwd_err_corr_on,
  input wire logic fec_length_conflict,
  input wire logic [4:0] preamble_bytes,
  input wire logic tx_preamble_sync_on,
  input wire logic tx_sync_twice,
  input wire logic rx_search_on,
  input wire logic rx_cs_gate,
  input wire logic rx_qualified,
  input wire logic [11:0] hop_step,
  input wire logic [26:0] op_freq
);
  logic [2:0] mode_q;
  logic [2:0] pre_q;
  logic fec_q;
  logic [1:0] exp_q;
  logic [7:0] mant_q;
  // Shadow of writable fields, so checks need no internal probes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= SYNC_MODE_RST;
      {fec_q, pre_q, exp_q} <= {FEC_RST, PREAMBLE_RST, STEP_EXP_RST};
      mant_q <= STEP_MANT_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == SYNC_CFG_ADDR)
        mode_q <= reg_wdata[2:0];
      if (reg_addr == PREAMBLE_FEC_ADDR)
        {fec_q, pre_q, exp_q} <= {reg_wdata[7:4], reg_wdata[1:0]};
      if (reg_addr == STEP_FINE_ADDR)
        mant_q <= reg_wdata;
    end
  end
  ////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_PRE_LEN: assert property (
    $past(arst_n) |-> preamble_bytes == PREAMBLE_BYTES[$past(pre_q)]) else $error("bad len");
  AST_FEC: assert property (
    $past(arst_n) |-> fwd_err_corr_on == $past(fec_q)) else $error("bad fec");
  AST_CONFLICT: assert property (
    $past(arst_n) |-> fec_length_conflict == ($past(fec_q) && $past(packet_ctrl_low) != 2'h0))
    else $error("bad conflict");
  AST_RSV: assert property (
    $past(reg_addr) == PREAMBLE_FEC_ADDR |-> reg_rdata[3:2] == 2'h0) else $error("bad rsv");
  AST_STEP: assert property (
    $past(arst_n) |-> hop_step == (12'h100 + 12'($past(mant_q))) << $past(exp_q))
    else $error("bad step");
  AST_FREQ: assert property (
    $past(arst_n, 2) |-> op_freq == 27'({$past(base_freq), 2'h0})
      + 27'((12'h100 + 12'($past(mant_q, 2))) << $past(exp_q, 2)) * 27'($past(hop_index)))
    else $error("bad freq");
  AST_TX: assert property (
    $past(arst_n) |-> tx_preamble_sync_on == ($past(mode_q[1:0]) != SYNC_NONE)
      && tx_sync_twice == ($past(mode_q[1:0]) == SYNC_32)) else $error("bad tx");
  AST_CS: assert property (
    $past(arst_n) |-> rx_cs_gate == $past(mode_q[2])) else $error("bad cs gate");
  AST_SEARCH: assert property (
    $past(arst_n) |-> rx_search_on == ($past(rx_enable) && $past(mode_q[1:0]) != SYNC_NONE))
    else $error("bad search");
  AST_PULSE: assert property (
    rx_qualified |=> !rx_qualified) else $error("long pulse");
endmodule : modem_cfg_sva
`default_nettype wire

/* tb/peer_radio.sv */
// Peer radio model: sends bit patterns, most significant bit first.
// Assumes the receiver takes one bit per clk edge with valid high.
`timescale 1ns/100ps
`default_nettype none
module peer_radio
(
  input wire logic clk,
  output logic bit_valid,
  output logic bit_out
);
  initial
  begin
    bit_valid = 1'b0;
    bit_out = 1'b0;
  end
  task automatic send(input logic [31:0] word, input int nbits);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      @(negedge clk);
      bit_valid = 1'b1;
      bit_out = word[i];
    end
    @(negedge clk);
    bit_valid = 1'b0;
    // Idle line must not repeat the last bit
    bit_out = ~bit_out;
  endtask : send
endmodule : peer_radio
`default_nettype wire

/* tb/modem_sync_preamble_hop_cfg_tb.sv */
// Self-checking bench for the modem configuration bank.
// Assumes peer_radio and modem_cfg_sva are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module modem_sync_preamble_hop_cfg_tb
  import modem_cfg_pkg::*;
;
  typedef struct {int sel; logic [26:0] exp;} note_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] packet_ctrl_low = 2'h0;
  logic rx_enable = 1'b0;
  logic carrier_sense = 1'b0;
  logic [15:0] sync_word = 16'hA5C3;
  logic [23:0] base_freq = 24'h000000;
  logic [7:0] hop_index = 8'h00;
  logic rx_bit_valid, rx_bit, fwd_err_corr_on, fec_length_conflict, tx_preamble_sync_on;
  logic tx_sync_twice, rx_search_on, rx_cs_gate, rx_qualified;
  logic [7:0] reg_rdata, d, m;
  logic [4:0] preamble_bytes;
  logic [11:0] hop_step, step;
  logic [26:0] op_freq;
  logic [2:0] md;
  logic cs, er, en, q;
  int failures = 0;
  int comparisons = 0;
  int qual_cnt = 0;
  int c0;
  note_t notes[$];
  note_t n;
  logic [4:0] pre_tbl [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
  string names [11] = '{"rdata", "preamble", "step", "freq", "fec", "txsync", "twice",
    "csgate", "qual", "conflict", "search"};
  always #2.5 clk = ~clk;
  modem_sync_preamble_hop_cfg dut (.*);
  peer_radio peer (.clk(clk), .bit_valid(rx_bit_valid), .bit_out(rx_bit));
  ////////////////////////////////
  function automatic logic [26:0] pick(input int s);
    case (s)
      0: return 27'(reg_rdata);
      1: return 27'(preamble_bytes);
      2: return 27'(hop_step);
      3: return op_freq;
      4: return 27'(fwd_err_corr_on);
      5: return 27'(tx_preamble_sync_on);
      6: return 27'(tx_sync_twice);
      7: return 27'(rx_cs_gate);
      8: return 27'(qual_cnt);
      9: return 27'(fec_length_conflict);
      default: return 27'(rx_search_on);
    endcase
  endfunction : pick
  task automatic note(input int s, input logic [26:0] e);
    notes.push_back('{s, e});
  endtask : note
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    repeat (2) @(negedge clk);
    note(0, 27'(v));
  endtask : rd
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Counted on the falling edge, clear of the output update
  always @(negedge clk)
    if (rx_qualified === 1'b1)
      qual_cnt <= qual_cnt + 1;
  always @(posedge clk)
  begin
    #1;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      `CHK(names[n.sel], n.exp, pick(n.sel))
    end
  end
  initial
  begin
    #100000;
    failures++;
    $display("watchdog expired");
    finish_test();
  end
  ////////////////////////////////
  initial
  begin
    void'($urandom(32'hB4353E6B));
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    rd(SYNC_CFG_ADDR, 8'h02);
    rd(PREAMBLE_FEC_ADDR, 8'h22);
    rd(STEP_FINE_ADDR, 8'hF8);
    rd(6'h20, 8'h00);
    note(1, 27'h4);
    note(2, 27'((12'h100 + 12'(STEP_MANT_RST)) << STEP_EXP_RST));
    note(4, 27'h0);
    wr(PREAMBLE_FEC_ADDR, 8'hFF);
    rd(PREAMBLE_FEC_ADDR, 8'hF3);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom());
      d[6:4] = 3'(i);
      m = 8'($urandom());
      base_freq = 24'($urandom());
      hop_index = 8'($urandom());
      packet_ctrl_low = 2'($urandom());
      wr(PREAMBLE_FEC_ADDR, d);
      wr(STEP_FINE_ADDR, m);
      settle();
      step = (12'h100 + 12'(m)) << d[1:0];
      note(1, 27'(pre_tbl[i]));
      note(4, 27'(d[7]));
      note(9, 27'(d[7] && packet_ctrl_low != 2'h0));
      note(2, 27'(step));
      note(3, 27'({base_freq, 2'h0}) + 27'(step) * 27'(hop_index));
      rd(PREAMBLE_FEC_ADDR, d & 8'hF3);
    end
    $display("test preamble and step done");
    for (int j = 0; j < 32; j++)
    begin
      md = 3'(j / 4);
      cs = j[0];
      er = j[1];
      en = (j != 25);
      carrier_sense = 1'b0;
      // Idle the search so no bits of the last pass linger in the correlator
      rx_enable = 1'b0;
      wr(SYNC_CFG_ADDR, {5'($urandom()), md});
      rd(SYNC_CFG_ADDR, {5'h00, md});
      rx_enable = en;
      settle();
      c0 = qual_cnt;
      note(5, 27'(md[1:0] != 2'h0));
      note(6, 27'(md[1:0] == 2'h3));
      note(7, 27'(md[2]));
      note(10, 27'(en && md[1:0] != 2'h0));
      carrier_sense = cs;
      peer.send({sync_word, sync_word} ^ 32'(er), md[1:0] == 2'h3 ? 32 : 16);
      settle();
      settle();
      q = md == 3'h4 ? cs : md[1:0] != 2'h0 && (!md[2] || cs) && !(md[1:0] == 2'h2 && er);
      note(8, 27'(c0 + int'(q && en)));
    end
    $display("test sync modes done");
    settle();
    finish_test();
  end
endmodule : modem_sync_preamble_hop_cfg_tb
bind modem_sync_preamble_hop_cfg modem_cfg_sva chk (.*);
`default_nettype wire
